// >>> src/wwkm_defs.vh
// Constants for the window watchdog kick monitor
`ifndef WWKM_DEFS_VH
`define WWKM_DEFS_VH

`define WWKM_CLK_MHZ       50
`define WWKM_TUP_RES_US    1000
`define WWKM_TUP_NC_US     10000
`define WWKM_TRST_RES_US   200
`define WWKM_TRST_NC_US    10000
`define WWKM_TUP_RES_CYC   (`WWKM_TUP_RES_US * `WWKM_CLK_MHZ)
`define WWKM_TUP_NC_CYC    (`WWKM_TUP_NC_US * `WWKM_CLK_MHZ)
`define WWKM_TRST_RES_CYC  (`WWKM_TRST_RES_US * `WWKM_CLK_MHZ)
`define WWKM_TRST_NC_CYC   (`WWKM_TRST_NC_US * `WWKM_CLK_MHZ)

`define WWKM_PIN_CAP       2'h0
`define WWKM_PIN_RES       2'h1
`define WWKM_PIN_NC        2'h2

`define WWKM_SEL_HALF      2'h0
`define WWKM_SEL_OFF       2'h1
`define WWKM_SEL_QUART     2'h2
`define WWKM_SEL_EIGHTH    2'h3

`define WWKM_OFS_CTRL      6'h00
`define WWKM_OFS_STATUS    6'h01
`define WWKM_OFS_INT_STAT  6'h02
`define WWKM_OFS_INT_MASK  6'h03
`define WWKM_OFS_CAP_UP    6'h04
`define WWKM_OFS_CAP_RST   6'h05

`define WWKM_CTRL_SW_OFF   0
`define WWKM_EV_TMO        0
`define WWKM_EV_EARLY      1
`define WWKM_EV_LATE       2
`define WWKM_EV_REL        3
`define WWKM_EV_W          4

`define WWKM_CTRL_RST      32'h00000000
`define WWKM_MASK_RST      4'h0
`define WWKM_CAP_UP_RST    32'h00001000
`define WWKM_CAP_RST_RST   32'h00000400

`define WWKM_RESP_OKAY     2'h0
`define WWKM_RESP_SLVERR   2'h2

`endif

// >>> src/wwkm_top.v
// Window watchdog kick monitor with AXI4-Lite register slave
// What this block and its supervisor do
// RL1: Supervisor gives one falling kick edge inside the window each period.
// RL2: During power-up, kicks are ignored and watchdog is off until delay ends.
// RL3: Kick activity is ignored while the reset output is low.
// RL4: Kick activity is ignored while the select inputs disable the watchdog.
// RL5: Supervisor holds the kick input at a defined level while disabled.
// RL6: A detected timeout drives the reset output low.
// RL7: Reset output stays low for exactly the reset delay, then releases.
// RL8: While disabled, reset output stays high whatever the kick input does.
// RL9: Select inputs plus timeout pin choose window ratio, timeout and disable.
// RL10: Reset delay pin picks preset delays by resistor or open, else capacitor.
// RL11: Early kick or missing kick by upper boundary is a timeout.
// RL12: After reset release a fresh window starts from the release.
`timescale 1ns/1ps
`default_nettype none
`include "wwkm_defs.vh"

module wwkm_top #(
	parameter        ADDR_W      = 8,
	parameter [31:0] TUP_RES_CYC  = `WWKM_TUP_RES_CYC,
	parameter [31:0] TUP_NC_CYC   = `WWKM_TUP_NC_CYC,
	parameter [31:0] TRST_RES_CYC = `WWKM_TRST_RES_CYC,
	parameter [31:0] TRST_NC_CYC  = `WWKM_TRST_NC_CYC
)(
	input  wire              aclk,
	input  wire              aresetn,
	input  wire [ADDR_W-1:0] s_axi_awaddr,
	input  wire [2:0]        s_axi_awprot,
	input  wire              s_axi_awvalid,
	output wire              s_axi_awready,
	input  wire [31:0]       s_axi_wdata,
	input  wire [3:0]        s_axi_wstrb,
	input  wire              s_axi_wvalid,
	output wire              s_axi_wready,
	output wire [1:0]        s_axi_bresp,
	output wire              s_axi_bvalid,
	input  wire              s_axi_bready,
	input  wire [ADDR_W-1:0] s_axi_araddr,
	input  wire [2:0]        s_axi_arprot,
	input  wire              s_axi_arvalid,
	output wire              s_axi_arready,
	output wire [31:0]       s_axi_rdata,
	output wire [1:0]        s_axi_rresp,
	output wire              s_axi_rvalid,
	input  wire              s_axi_rready,
	input  wire              window_select_a,
	input  wire              window_select_b,
	input  wire [1:0]        timeout_program_pin,
	input  wire [1:0]        reset_delay_program_pin,
	input  wire              kick_input,
	output wire              timeout_reset_out_n,
	output wire              irq
);

	localparam [1:0] ST_PWRUP = 2'h0;
	localparam [1:0] ST_RUN   = 2'h1;
	localparam [1:0] ST_FIRE  = 2'h2;
	localparam [1:0] ST_OFF   = 2'h3;

	// Byte-lane merge of a write into a 32-bit register
	function [31:0] strb_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer      i;
		begin
			strb_merge = old_val;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
		end
	endfunction

	// Preset or software time for a program pin
	function [31:0] pin_time;
		input [1:0]  code;
		input [31:0] cap_val;
		input [31:0] res_val;
		input [31:0] nc_val;
		begin
			case (code)
				`WWKM_PIN_RES: pin_time = res_val;
				`WWKM_PIN_NC:  pin_time = nc_val;
				default:       pin_time = cap_val;
			endcase
			if (pin_time == 32'h00000000)
				pin_time = 32'h00000001;
		end
	endfunction

	reg        awready_reg;
	reg        wready_reg;
	reg        bvalid_reg;
	reg [1:0]  bresp_reg;
	reg        arready_reg;
	reg        rvalid_reg;
	reg [1:0]  rresp_reg;
	reg [31:0] rdata_reg;
	reg [31:0] ctrl_reg;
	reg [3:0]  stat_reg;
	reg [3:0]  mask_reg;
	reg [31:0] cap_up_reg;
	reg [31:0] cap_rst_reg;
	reg        irq_reg;
	reg [1:0]  state_reg;
	reg [31:0] cnt_reg;
	reg        out_n_reg;
	reg        kick_prev_reg;

	reg [1:0]  state_next;
	reg [31:0] cnt_next;
	reg        out_n_next;
	reg [3:0]  ev;
	reg [3:0]  stat_next;
	reg [3:0]  w1c;
	reg [31:0] rd_mux;
	reg        rd_hit;
	reg        wr_hit;

	wire [1:0]  sel      = {window_select_a, window_select_b};
	wire [5:0]  wr_idx   = s_axi_awaddr[7:2];
	wire [5:0]  rd_idx   = s_axi_araddr[7:2];
	wire        wr_go    = awready_reg & wready_reg;
	wire        kick_ev  = kick_prev_reg & ~kick_input;
	wire        wd_off   = (sel == `WWKM_SEL_OFF) |
			       ctrl_reg[`WWKM_CTRL_SW_OFF];                // RL9
	wire [31:0] t_upper  = pin_time(timeout_program_pin, cap_up_reg,
				TUP_RES_CYC, TUP_NC_CYC);          // RL9
	wire [31:0] t_delay  = pin_time(reset_delay_program_pin, cap_rst_reg,
				TRST_RES_CYC, TRST_NC_CYC);        // RL10
	reg  [31:0] t_lower;

	// Window ratio from the select inputs
	always @*
	begin
		case (sel)
			`WWKM_SEL_QUART:  t_lower = t_upper >> 2;  // RL9
			`WWKM_SEL_EIGHTH: t_lower = t_upper >> 3;  // RL9
			default:          t_lower = t_upper >> 1;  // RL9
		endcase
	end

	// Watchdog sequencing
	always @*
	begin
		state_next = state_reg;
		cnt_next   = cnt_reg + 32'h00000001;
		out_n_next = out_n_reg;
		ev         = 4'h0;
		case (state_reg)
			ST_PWRUP:
			begin
				out_n_next = 1'b0;
				if (cnt_reg >= t_delay - 32'h00000001)        // RL2
				begin
					cnt_next   = 32'h00000000;
					out_n_next = 1'b1;
					state_next = wd_off ? ST_OFF : ST_RUN;
				end
			end
			ST_RUN:
			begin
				if (wd_off)
				begin
					state_next = ST_OFF;                      // RL4
					cnt_next   = 32'h00000000;
				end
				else if (kick_ev && cnt_reg < t_lower)        // RL11
				begin
					ev[`WWKM_EV_TMO]   = 1'b1;
					ev[`WWKM_EV_EARLY] = 1'b1;
					out_n_next         = 1'b0;                // RL6
					cnt_next           = 32'h00000000;
					state_next         = ST_FIRE;
				end
				else if (kick_ev)
					cnt_next = 32'h00000000;                  // RL11
				else if (cnt_reg >= t_upper - 32'h00000001)   // RL11
				begin
					ev[`WWKM_EV_TMO]  = 1'b1;
					ev[`WWKM_EV_LATE] = 1'b1;
					out_n_next        = 1'b0;                 // RL6
					cnt_next          = 32'h00000000;
					state_next        = ST_FIRE;
				end
			end
			ST_FIRE:
			begin
				// Kick edges are not looked at here
				if (cnt_reg >= t_delay - 32'h00000001)        // RL3 RL7
				begin
					ev[`WWKM_EV_REL] = 1'b1;
					out_n_next       = 1'b1;                  // RL7
					cnt_next         = 32'h00000000;          // RL12
					state_next       = wd_off ? ST_OFF : ST_RUN;
				end
			end
			ST_OFF:
			begin
				out_n_next = 1'b1;                            // RL8
				cnt_next   = 32'h00000000;
				if (!wd_off)
					state_next = ST_RUN;
			end
			default:
			begin
				state_next = ST_PWRUP;
				cnt_next   = 32'h00000000;
				out_n_next = 1'b0;
			end
		endcase
	end

	// Write-one-to-clear; a new event wins over the clear
	always @*
	begin
		w1c = 4'h0;
		if (wr_go && wr_idx == `WWKM_OFS_INT_STAT && s_axi_wstrb[0])
			w1c = s_axi_wdata[3:0];
		stat_next = (stat_reg & ~w1c) | ev;
	end

	always @*
	begin
		case (wr_idx)
			`WWKM_OFS_CTRL, `WWKM_OFS_INT_STAT, `WWKM_OFS_INT_MASK,
			`WWKM_OFS_CAP_UP, `WWKM_OFS_CAP_RST: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always @*
	begin
		rd_hit = 1'b1;
		case (rd_idx)
			`WWKM_OFS_CTRL:     rd_mux = ctrl_reg;
			`WWKM_OFS_STATUS:   rd_mux = {24'h000000, timeout_program_pin,
						reset_delay_program_pin, sel,
						out_n_reg, wd_off};
			`WWKM_OFS_INT_STAT: rd_mux = {28'h0000000, stat_reg};
			`WWKM_OFS_INT_MASK: rd_mux = {28'h0000000, mask_reg};
			`WWKM_OFS_CAP_UP:   rd_mux = cap_up_reg;
			`WWKM_OFS_CAP_RST:  rd_mux = cap_rst_reg;
			default:
			begin
				rd_mux = 32'h00000000;
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_reg     <= ST_PWRUP;
			cnt_reg       <= 32'h00000000;
			out_n_reg     <= 1'b0;
			kick_prev_reg <= 1'b0;
			stat_reg      <= 4'h0;
			irq_reg       <= 1'b0;
		end
		else
		begin
			state_reg     <= state_next;
			cnt_reg       <= cnt_next;
			out_n_reg     <= out_n_next;
			kick_prev_reg <= kick_input;
			stat_reg      <= stat_next;
			irq_reg       <= |(stat_reg & mask_reg);
		end
	end

	// Write channel: address and data taken together
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `WWKM_RESP_OKAY;
			ctrl_reg    <= `WWKM_CTRL_RST;
			mask_reg    <= `WWKM_MASK_RST;
			cap_up_reg  <= `WWKM_CAP_UP_RST;
			cap_rst_reg <= `WWKM_CAP_RST_RST;
		end
		else
		begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !wr_go && !bvalid_reg)
			begin
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
			if (wr_go)
			begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit ? `WWKM_RESP_OKAY : `WWKM_RESP_SLVERR;
				case (wr_idx)
					`WWKM_OFS_CTRL:
						ctrl_reg <= strb_merge(ctrl_reg, s_axi_wdata,
							s_axi_wstrb) & 32'h00000001;
					`WWKM_OFS_INT_MASK:
						if (s_axi_wstrb[0])
							mask_reg <= s_axi_wdata[3:0];
					`WWKM_OFS_CAP_UP:
						cap_up_reg <= strb_merge(cap_up_reg, s_axi_wdata,
							s_axi_wstrb);
					`WWKM_OFS_CAP_RST:
						cap_rst_reg <= strb_merge(cap_rst_reg, s_axi_wdata,
							s_axi_wstrb);
					default:
						ctrl_reg <= ctrl_reg;
				endcase
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Read channel
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= `WWKM_RESP_OKAY;
			rdata_reg   <= 32'h00000000;
		end
		else
		begin
			arready_reg <= 1'b0;
			if (s_axi_arvalid && !arready_reg && !rvalid_reg)
				arready_reg <= 1'b1;
			if (arready_reg)
			begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_mux;
				rresp_reg  <= rd_hit ? `WWKM_RESP_OKAY : `WWKM_RESP_SLVERR;
			end
			else if (rvalid_reg && s_axi_rready)
				rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_awready       = awready_reg;
	assign s_axi_wready        = wready_reg;
	assign s_axi_bvalid        = bvalid_reg;
	assign s_axi_bresp         = bresp_reg;
	assign s_axi_arready       = arready_reg;
	assign s_axi_rvalid        = rvalid_reg;
	assign s_axi_rresp         = rresp_reg;
	assign s_axi_rdata         = rdata_reg;
	assign timeout_reset_out_n = out_n_reg;
	assign irq                 = irq_reg;

endmodule

`default_nettype wire

// >>> tb/wwkm_props.sv
// Property checker for the window watchdog kick monitor
`timescale 1ns/1ps
`default_nettype none
module wwkm_props #(
	parameter [31:0] TUP_RES_CYC  = 32'h1,
	parameter [31:0] TUP_NC_CYC   = 32'h1,
	parameter [31:0] TRST_RES_CYC = 32'h1,
	parameter [31:0] TRST_NC_CYC  = 32'h1
)(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       window_select_a,
	input wire logic       window_select_b,
	input wire logic [1:0] timeout_program_pin,
	input wire logic [1:0] reset_delay_program_pin,
	input wire logic       kick_input,
	input wire logic       timeout_reset_out_n
);
	logic [31:0] hc, lc, up, lo;
	logic        kp, trk, sh;
	wire         off  = !window_select_a && window_select_b;
	wire         kick = kp && !kick_input;
	wire         ok   = trk && !off && timeout_reset_out_n && timeout_program_pin != 2'h0;
	always_comb
	begin
		up = (timeout_program_pin == 2'h1) ? TUP_RES_CYC : TUP_NC_CYC;
		lo = !window_select_a ? up >> 1 : (window_select_b ? up >> 3 : up >> 2);
	end
	// Window tracking drops after any register write, which may hide a software disable
	always_ff @(posedge aclk)
	begin
		kp  <= kick_input;
		sh  <= aresetn && (sh || timeout_reset_out_n);
		lc  <= timeout_reset_out_n ? 32'h0 : lc + 32'h1;
		hc  <= (!timeout_reset_out_n || (kick && hc >= lo)) ? 32'h0 : hc + 32'h1;
		trk <= aresetn && !off && !s_axi_awready && (trk || !timeout_reset_out_n);
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	pwr_low_a: assert property (
		$rose(aresetn) |-> !timeout_reset_out_n [*8]) else $error("power-up hold too short");
	rst_len_a: assert property (
		$rose(timeout_reset_out_n) && sh && reset_delay_program_pin != 2'h0 |->
		lc == ((reset_delay_program_pin == 2'h1) ? TRST_RES_CYC : TRST_NC_CYC))
		else $error("reset pulse length wrong");
	late_tmo_a: assert property (
		ok && hc == up - 32'h1 && !kick |=> !timeout_reset_out_n) else $error("late timeout missed");
	early_tmo_a: assert property (
		ok && kick && hc < lo |=> !timeout_reset_out_n) else $error("early kick not caught");
	kick_ok_a: assert property (
		ok && kick && hc >= lo && hc < up - 32'h1 |=> timeout_reset_out_n [*2])
		else $error("valid kick caused reset");
	dis_high_a: assert property (
		off && timeout_reset_out_n |=> timeout_reset_out_n) else $error("output fell while off");
	aw_pair_a: assert property (
		s_axi_awready |-> s_axi_wready ##1 s_axi_bvalid) else $error("write handshake broken");
	r_after_a: assert property (
		s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
endmodule
bind wwkm_top wwkm_props #(.TUP_RES_CYC(TUP_RES_CYC), .TUP_NC_CYC(TUP_NC_CYC),
	.TRST_RES_CYC(TRST_RES_CYC), .TRST_NC_CYC(TRST_NC_CYC)) u_props (.*);
`default_nettype wire

// >>> tb/wwkm_kicker.sv
// Supervising party model that kicks the watchdog
`timescale 1ns/1ps
`default_nettype none
module wwkm_kicker (
	input  wire logic        aclk,
	input  wire logic        out_n,
	input  wire logic [31:0] fall_at,
	input  wire logic        spam,
	output var  logic        kick
);
	logic [31:0] cnt = 32'h0;
	initial kick = 1'b1;
	always @(posedge aclk)
	begin
		kick <= 1'b1;
		cnt  <= cnt + 32'h1;
		if (!out_n || fall_at == 32'h0)
			cnt <= 32'h0;
		else if (cnt + 32'h1 >= fall_at)
		begin
			kick <= 1'b0;
			cnt  <= 32'h0;
		end
		if (spam)
			kick <= !kick;
	end
endmodule
`default_nettype wire

// >>> tb/tb_window_watchdog_kick_monitor.sv
// Self-checking bench for the window watchdog kick monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
$display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_window_watchdog_kick_monitor;
	localparam int U1 = 40;
	localparam int U2 = 80;
	localparam int D1 = 10;
	localparam int D2 = 20;
	localparam int CU = 48;
	localparam int CD = 12;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, window_select_a, window_select_b, spam;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, fall_at;
	logic [1:0]  timeout_program_pin, reset_delay_program_pin;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         kick_input, timeout_reset_out_n, irq;
	wire  [1:0]  s_axi_bresp, s_axi_rresp;
	wire  [31:0] s_axi_rdata;
	int          err_count, samples_checked, cyc, n, h, t0;
	wwkm_top #(.TUP_RES_CYC(U1), .TUP_NC_CYC(U2), .TRST_RES_CYC(D1), .TRST_NC_CYC(D2)) u_dut (
		.s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF), .*);
	wwkm_kicker u_kick (.aclk(aclk), .out_n(timeout_reset_out_n), .fall_at(fall_at),
		.spam(spam), .kick(kick_input));
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		`CHK("bresp", s_axi_bresp, e)
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		`CHK("rdata", s_axi_rdata, d)
		`CHK("rresp", s_axi_rresp, e)
	endtask
	// Counts edges at which the reset output is sampled at level l
	task automatic seg(input logic l, output int c);
		c = 0;
		while (timeout_reset_out_n === l)
		begin
			c++;
			@(posedge aclk);
		end
	endtask
	task automatic lows(output int c);
		c = 0;
		repeat (3 * U1)
		begin
			@(posedge aclk);
			c += (timeout_reset_out_n !== 1'b1);
		end
	endtask
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			err_count++;
			close_out();
		end
	end
	initial
	begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{window_select_a, window_select_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		timeout_program_pin = 2'h1;
		reset_delay_program_pin = 2'h1;
		fall_at = 0;
		spam = 1'b1;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t0 = cyc;
		repeat (D1 - 3) @(posedge aclk);
		spam <= 1'b0;
		seg(1'b0, n);
		`CHK("powerup", (cyc - t0 >= D1) && (cyc - t0 <= D1 + 2), 1'b1)
		rd(8'h04, 32'h00000052, 2'h0);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		rd(8'h10, 32'h00001000, 2'h0);
		rd(8'h14, 32'h00000400, 2'h0);
		rd(8'h18, 32'h0, 2'h2);
		wr(8'h04, 32'h0, 2'h2);
		wr(8'h18, 32'h0, 2'h2);
		wr(8'h0C, 32'h0000000F, 2'h0);
		rd(8'h0C, 32'h0000000F, 2'h0);
		$display("registers done");
		// Wait for a whole low pulse so the next window starts at a known edge
		seg(1'b1, n);
		seg(1'b0, n);
		wr(8'h10, CU, 2'h0);
		wr(8'h14, CD, 2'h0);
		rd(8'h10, CU, 2'h0);
		rd(8'h14, CD, 2'h0);
		// Capacitor-programmed times first, then the two presets
		for (int p = 3; p > 0; p--)
		begin
			timeout_program_pin <= (p == 3) ? 2'h0 : p[1:0];
			reset_delay_program_pin <= (p == 3) ? 2'h0 : p[1:0];
			wr(8'h08, 32'h0000000F, 2'h0);
			seg(1'b1, n);
			seg(1'b0, n);
			seg(1'b1, h);
			`CHK("high", h, (p == 1) ? U1 : ((p == 2) ? U2 : CU))
			seg(1'b0, h);
			`CHK("low", h, (p == 1) ? D1 : ((p == 2) ? D2 : CD))
		end
		rd(8'h08, 32'h0000000D, 2'h0);
		`CHK("irq", irq, 1'b1)
		wr(8'h0C, 32'h0, 2'h0);
		@(posedge aclk);
		`CHK("irq", irq, 1'b0)
		wr(8'h0C, 32'h1, 2'h0);
		wr(8'h08, 32'h1, 2'h0);
		@(posedge aclk);
		`CHK("irq", irq, 1'b0)
		$display("timeout done");
		// No kicks yet, so a timeout comes; each window test then starts at a release
		seg(1'b1, n);
		for (int s = 0; s < 4; s++)
		begin
			if (s == 1)
				continue;
			{window_select_a, window_select_b} <= s[1:0];
			h = U1 >> ((s == 0) ? 1 : s);
			fall_at <= h + 2;
			seg(1'b0, n);
			lows(n);
			`CHK("keep", n, 0)
			fall_at <= h - 1;
			seg(1'b1, n);
			seg(1'b0, n);
			seg(1'b1, n);
			`CHK("early", n, h)
		end
		$display("window done");
		seg(1'b0, n);
		{window_select_a, window_select_b} <= 2'h1;
		spam <= 1'b1;
		lows(n);
		`CHK("off", n, 0)
		rd(8'h04, 32'h00000057, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		{window_select_a, window_select_b} <= 2'h0;
		lows(n);
		`CHK("swoff", n, 0)
		$display("disable done");
		close_out();
	end
endmodule
`default_nettype wire
